// *** core/rtc_consts.svh ***
/*
  Register indices, field positions, limits, reset values and divider counts for the real time clock.
  Included by bare name from both the design and the testbench, guarded against repeats; holds definitions only.
*/
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define RTC_IDX_IRQ_EN     8'h42
`define RTC_IDX_CTRL       8'h43
`define RTC_IDX_FLAGS      8'h44
`define RTC_IDX_ALM_MIN    8'h45
`define RTC_IDX_ALM_HOUR   8'h46
`define RTC_IDX_SEC        8'h47
`define RTC_IDX_MIN        8'h48
`define RTC_IDX_HOUR       8'h49
`define RTC_IDX_DAY        8'h4A
`define RTC_IDX_MONTH      8'h4B
`define RTC_IDX_YEAR       8'h4C
`define RTC_IDX_DOW        8'h4D
`define RTC_IDX_CHRONO     8'h4E

// Control register fields.
`define RTC_CTRL_CLR_BIT   7
`define RTC_CTRL_CHRONO_ENABLE_BIT  6
`define RTC_CTRL_MODEN_BIT 5
`define RTC_FSEL_MSB       2
`define RTC_FSEL_HIGH_BIT  2

// Oscillator select codes.
`define RTC_FSEL_32K768    3'h0
`define RTC_FSEL_32K000    3'h2
`define RTC_FSEL_38K400    3'h3

// Oscillator edges per sub-second tick (128 Hz for 32.768 kHz, 100 Hz otherwise).
`define RTC_PRE_32K768     10'h100
`define RTC_PRE_32K000     10'h140
`define RTC_PRE_38K400     10'h180
`define RTC_PRE_64K000     10'h280
`define RTC_PRE_76K800     10'h300

// Sub-second ticks per quarter second, minus one, and per second, minus one.
`define RTC_QTR_128        5'h1F
`define RTC_QTR_100        5'h18
`define RTC_SUB_128        7'h7F
`define RTC_SUB_100        7'h63
`define RTC_QTR_LAST       2'h3

// Counter limits and reset values.
`define RTC_SEC_MAX        6'h3B
`define RTC_HOUR_MAX       5'h17
`define RTC_DAY_FIRST      5'h01
`define RTC_MONTH_FIRST    4'h1
`define RTC_MONTH_MAX      4'hC
`define RTC_FEB            4'h2
`define RTC_DOW_MAX        3'h6
`define RTC_YEAR_MAX       8'h63
`define RTC_YEAR_MIN       8'h9D
`define RTC_HTRANS_NONSEQ  2'h2

`endif

// *** core/rtc_pkg.sv ***
/*
  Types shared by the real time clock: the eight event flags and the bus phase states.
  Assumes rtc_consts.svh supplies the numeric constants.
*/
package rtc_pkg;

  // One bit per event, bit 7 down to bit 0.
  typedef struct packed {
    logic alarm;
    logic chrono;
    logic date;
    logic hour;
    logic minute;
    logic second;
    logic halfSec;
    logic quarterSec;
  } rtc_flags_t;

  typedef enum logic {BUS_IDLE, BUS_DATA} bus_state_t;

endpackage

// *** core/rtc_calendar_alarm_chrono.sv ***
/*
  Real time clock and calendar with hour/minute alarm, half and quarter second ticks and a
  hundredths chronograph, reached as an AHB-Lite slave with one wait state per transfer.
  Assumes oscRefClock, stopMode and oscRunInStop are synchronous to sys_clk, and that this
  is the only slave so hready equals hreadyout.
*/
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "rtc_consts.svh"

module rtc_calendar_alarm_chrono
  import rtc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        oscRefClock,
  input  wire logic        stopMode,
  input  wire logic        oscRunInStop,
  output logic             irq
);

  // Days in the given month, February stretched in leap years.
  function automatic logic [4:0] lastDay(input logic [3:0] m, input logic [7:0] y);
    case (m)
      4'h4, 4'h6, 4'h9, 4'hB: lastDay = 5'h1E;
      `RTC_FEB:               lastDay = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      default:                lastDay = 5'h1F;
    endcase
  endfunction

  // Oscillator edges per sub-second tick for a select code.
  function automatic logic [9:0] preDiv(input logic [2:0] s);
    if (s[`RTC_FSEL_HIGH_BIT])
    begin
      preDiv = s[0] ? `RTC_PRE_76K800 : `RTC_PRE_64K000;
    end
    else
    begin
      case (s)
        `RTC_FSEL_32K000: preDiv = `RTC_PRE_32K000;
        `RTC_FSEL_38K400: preDiv = `RTC_PRE_38K400;
        default:          preDiv = `RTC_PRE_32K768;
      endcase
    end
  endfunction

  // Flags that a read of the given register index clears once armed.
  function automatic rtc_flags_t clearMask(input logic [7:0] idx);
    clearMask = '0;
    case (idx)
      `RTC_IDX_ALM_HOUR: clearMask.alarm = 1'b1;
      `RTC_IDX_DAY:      clearMask.date = 1'b1;
      `RTC_IDX_HOUR:     clearMask.hour = 1'b1;
      `RTC_IDX_MIN:      clearMask.minute = 1'b1;
      `RTC_IDX_SEC:      clearMask.second = 1'b1;
      `RTC_IDX_CHRONO:
      begin
        clearMask.chrono = 1'b1;
        clearMask.halfSec = 1'b1;
        clearMask.quarterSec = 1'b1;
      end
      default:           clearMask = '0;
    endcase
  endfunction

  bus_state_t  busState_reg;
  logic [7:0]  busIdx_reg;
  logic        busHit_reg;
  logic        busWrite_reg;
  rtc_flags_t  irqEnables_reg;
  rtc_flags_t  flags_reg;
  rtc_flags_t  flags_next;
  rtc_flags_t  armed_reg;
  rtc_flags_t  clrSel;
  rtc_flags_t  enablesNext;
  logic        chronoEnable_reg;
  logic        moduleEnable_reg;
  logic [2:0]  freqSel_reg;
  logic        freqLocked_reg;
  logic [5:0]  almMin_reg;
  logic [4:0]  almHour_reg;
  logic [5:0]  sec_reg;
  logic [5:0]  min_reg;
  logic [4:0]  hour_reg;
  logic [4:0]  day_reg;
  logic [3:0]  month_reg;
  logic [7:0]  year_reg;
  logic [2:0]  dow_reg;
  logic [6:0]  chrono_reg;
  logic [6:0]  chronoTicks_reg;
  logic [9:0]  preCnt_reg;
  logic [4:0]  qtrCnt_reg;
  logic [1:0]  qtrIdx_reg;
  logic        oscPrev_reg;
  logic        matchPrev_reg;
  logic        commit;
  logic        wr;
  logic        rd;
  logic [7:0]  wd;
  logic        run;
  logic        is128;
  logic        subTick;
  logic        qtrTick;
  logic        halfTick;
  logic        secTick;
  logic        minTick;
  logic        hourTick;
  logic        dayTick;
  logic        monthTick;
  logic        chronoTick;
  logic        chronoClr;
  logic        match;
  logic [6:0]  subMax;
  logic [13:0] chronoScaled;
  logic [7:0]  rdValue;

  // Bus commit happens on the wait-state cycle of each data phase whose address is word aligned with haddr bits 31:10 zero.
  assign commit = (busState_reg == BUS_DATA) && busHit_reg;
  assign wr     = commit && busWrite_reg;
  assign rd     = commit && !busWrite_reg;
  assign wd     = hwdata[7:0];

  // Halts in stop mode unless the oscillator keeps running; wait mode does not stop it.
  assign run        = moduleEnable_reg && !(stopMode && !oscRunInStop);
  assign is128      = (freqSel_reg == `RTC_FSEL_32K768) || (freqSel_reg == 3'h1);
  assign subMax     = is128 ? `RTC_SUB_128 : `RTC_SUB_100;
  assign subTick    = run && oscRefClock && !oscPrev_reg && (preCnt_reg == preDiv(freqSel_reg) - 10'h001);
  assign qtrTick    = subTick && (qtrCnt_reg == (is128 ? `RTC_QTR_128 : `RTC_QTR_100));
  assign halfTick   = qtrTick && qtrIdx_reg[0];
  assign secTick    = qtrTick && (qtrIdx_reg == `RTC_QTR_LAST);
  assign minTick    = secTick && (sec_reg == `RTC_SEC_MAX);
  assign hourTick   = minTick && (min_reg == `RTC_SEC_MAX);
  assign dayTick    = hourTick && (hour_reg == `RTC_HOUR_MAX);
  assign monthTick  = dayTick && (day_reg == lastDay(month_reg, year_reg));
  assign chronoTick = subTick && chronoEnable_reg;
  assign chronoClr  = wr && (busIdx_reg == `RTC_IDX_CTRL) && wd[`RTC_CTRL_CLR_BIT];
  assign match      = (min_reg == almMin_reg) && ({1'b0, hour_reg} == {1'b0, almHour_reg});
  assign chronoScaled = (chronoTicks_reg == subMax) ? 14'h0000 : {7'h00, chronoTicks_reg + 7'h01} * 14'h0019;

  // AHB-Lite slave: address phase captured, one wait state, then OKAY with registered data.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      busState_reg <= BUS_IDLE;
      busIdx_reg   <= 8'h00;
      busHit_reg   <= 1'b0;
      busWrite_reg <= 1'b0;
      hreadyout    <= 1'b1;
      hrdata       <= 32'h00000000;
      hresp        <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
      case (busState_reg)
        BUS_IDLE:
        begin
          if (hsel && htrans[1] && hready)
          begin
            busState_reg <= BUS_DATA;
            busIdx_reg   <= haddr[9:2];
            busHit_reg   <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
            busWrite_reg <= hwrite;
            hreadyout    <= 1'b0;
          end
        end
        BUS_DATA:
        begin
          busState_reg <= BUS_IDLE;
          hreadyout    <= 1'b1;
          hrdata       <= (!busWrite_reg && busHit_reg) ? {24'h000000, rdValue} : 32'h00000000;
        end
        default: busState_reg <= BUS_IDLE;
      endcase
    end
  end

  // Read multiplexer; unmapped indices read zero, the clear bit always reads zero.
  always_comb
  begin
    case (busIdx_reg)
      `RTC_IDX_IRQ_EN:   rdValue = irqEnables_reg;
      `RTC_IDX_CTRL:     rdValue = {1'b0, chronoEnable_reg, moduleEnable_reg, 2'b00, freqSel_reg};
      `RTC_IDX_FLAGS:    rdValue = flags_reg;
      `RTC_IDX_ALM_MIN:  rdValue = {2'b00, almMin_reg};
      `RTC_IDX_ALM_HOUR: rdValue = {3'b000, almHour_reg};
      `RTC_IDX_SEC:      rdValue = {2'b00, sec_reg};
      `RTC_IDX_MIN:      rdValue = {2'b00, min_reg};
      `RTC_IDX_HOUR:     rdValue = {3'b000, hour_reg};
      `RTC_IDX_DAY:      rdValue = {3'b000, day_reg};
      `RTC_IDX_MONTH:    rdValue = {4'h0, month_reg};
      `RTC_IDX_YEAR:     rdValue = year_reg;
      `RTC_IDX_DOW:      rdValue = {5'h00, dow_reg};
      `RTC_IDX_CHRONO:   rdValue = {1'b0, chrono_reg};
      default:           rdValue = 8'h00;
    endcase
  end

  // Interrupt enables and control bits; the select field locks after its first write.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      irqEnables_reg   <= '0;
      chronoEnable_reg <= 1'b0;
      moduleEnable_reg <= 1'b0;
      freqSel_reg      <= 3'h0;
      freqLocked_reg   <= 1'b0;
      almMin_reg       <= 6'h00;
      almHour_reg      <= 5'h00;
    end
    else if (wr)
    begin
      if (busIdx_reg == `RTC_IDX_IRQ_EN)
      begin
        irqEnables_reg <= wd;
      end
      if (busIdx_reg == `RTC_IDX_CTRL)
      begin
        chronoEnable_reg <= wd[`RTC_CTRL_CHRONO_ENABLE_BIT];
        moduleEnable_reg <= wd[`RTC_CTRL_MODEN_BIT];
        freqLocked_reg   <= 1'b1;
        if (!freqLocked_reg)
        begin
          freqSel_reg <= wd[`RTC_FSEL_MSB:0];
        end
      end
      if (busIdx_reg == `RTC_IDX_ALM_MIN)
      begin
        almMin_reg <= wd[5:0];
      end
      if (busIdx_reg == `RTC_IDX_ALM_HOUR)
      begin
        almHour_reg <= wd[4:0];
      end
    end
  end

  // Reference edge detector and divider chain down to quarter-second phases.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      oscPrev_reg <= 1'b0;
      preCnt_reg  <= 10'h000;
      qtrCnt_reg  <= 5'h00;
      qtrIdx_reg  <= 2'h0;
    end
    else
    begin
      oscPrev_reg <= oscRefClock;
      if (run && oscRefClock && !oscPrev_reg)
      begin
        preCnt_reg <= subTick ? 10'h000 : preCnt_reg + 10'h001;
      end
      if (subTick)
      begin
        qtrCnt_reg <= qtrTick ? 5'h00 : qtrCnt_reg + 5'h01;
      end
      if (qtrTick)
      begin
        qtrIdx_reg <= qtrIdx_reg + 2'h1;
      end
    end
  end

  // Time counters; any write wins over the tick, an invalid one is dropped.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sec_reg  <= 6'h00;
      min_reg  <= 6'h00;
      hour_reg <= 5'h00;
    end
    else
    begin
      if (wr && (busIdx_reg == `RTC_IDX_SEC))
      begin
        if (wd <= {2'b00, `RTC_SEC_MAX}) sec_reg <= wd[5:0];
      end
      else if (secTick)
      begin
        sec_reg <= (sec_reg == `RTC_SEC_MAX) ? 6'h00 : sec_reg + 6'h01;
      end
      if (wr && (busIdx_reg == `RTC_IDX_MIN))
      begin
        if (wd <= {2'b00, `RTC_SEC_MAX}) min_reg <= wd[5:0];
      end
      else if (minTick)
      begin
        min_reg <= (min_reg == `RTC_SEC_MAX) ? 6'h00 : min_reg + 6'h01;
      end
      if (wr && (busIdx_reg == `RTC_IDX_HOUR))
      begin
        if (wd <= {3'b000, `RTC_HOUR_MAX}) hour_reg <= wd[4:0];
      end
      else if (hourTick)
      begin
        hour_reg <= (hour_reg == `RTC_HOUR_MAX) ? 5'h00 : hour_reg + 5'h01;
      end
    end
  end

  // Calendar counters with month length and leap-year rollover.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      day_reg   <= `RTC_DAY_FIRST;
      month_reg <= `RTC_MONTH_FIRST;
      year_reg  <= 8'h00;
      dow_reg   <= 3'h0;
    end
    else
    begin
      if (wr && (busIdx_reg == `RTC_IDX_DAY))
      begin
        if ((wd[4:0] != 5'h00) && (wd[7:5] == 3'h0) && (wd[4:0] <= lastDay(month_reg, year_reg)))
        begin
          day_reg <= wd[4:0];
        end
      end
      else if (dayTick)
      begin
        day_reg <= monthTick ? `RTC_DAY_FIRST : day_reg + 5'h01;
      end
      if (wr && (busIdx_reg == `RTC_IDX_MONTH))
      begin
        if ((wd != 8'h00) && (wd <= {4'h0, `RTC_MONTH_MAX})) month_reg <= wd[3:0];
      end
      else if (monthTick)
      begin
        month_reg <= (month_reg == `RTC_MONTH_MAX) ? `RTC_MONTH_FIRST : month_reg + 4'h1;
      end
      if (wr && (busIdx_reg == `RTC_IDX_YEAR))
      begin
        if (($signed(wd) <= $signed(`RTC_YEAR_MAX)) && ($signed(wd) >= $signed(`RTC_YEAR_MIN)))
        begin
          year_reg <= wd;
        end
      end
      else if (monthTick && (month_reg == `RTC_MONTH_MAX))
      begin
        year_reg <= (year_reg == `RTC_YEAR_MAX) ? `RTC_YEAR_MIN : year_reg + 8'h01;
      end
      if (wr && (busIdx_reg == `RTC_IDX_DOW))
      begin
        if (wd <= {5'h00, `RTC_DOW_MAX}) dow_reg <= wd[2:0];
      end
      else if (dayTick)
      begin
        dow_reg <= (dow_reg == `RTC_DOW_MAX) ? 3'h0 : dow_reg + 3'h1;
      end
    end
  end

  // Chronograph: raw sub-second ticks, stored as hundredths after each tick.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      chronoTicks_reg <= 7'h00;
      chrono_reg      <= 7'h00;
    end
    else if (chronoClr)
    begin
      chronoTicks_reg <= 7'h00;
      chrono_reg      <= 7'h00;
    end
    else if (chronoTick)
    begin
      chronoTicks_reg <= (chronoTicks_reg == subMax) ? 7'h00 : chronoTicks_reg + 7'h01;
      chrono_reg      <= is128 ? chronoScaled[11:5] : ((chronoTicks_reg == subMax) ? 7'h00 : chronoTicks_reg + 7'h01);
    end
  end

  // Event flags: set beats clear; a status read arms, a matching register read clears.
  always_comb
  begin
    clrSel = '0;
    if (rd && (busIdx_reg != `RTC_IDX_FLAGS))
    begin
      clrSel = armed_reg & clearMask(busIdx_reg);
    end
    flags_next = flags_reg & ~clrSel;
    if (match && !matchPrev_reg) flags_next.alarm = 1'b1;
    if (chronoTick) flags_next.chrono = 1'b1;
    if (dayTick) flags_next.date = 1'b1;
    if (hourTick) flags_next.hour = 1'b1;
    if (minTick) flags_next.minute = 1'b1;
    if (secTick) flags_next.second = 1'b1;
    if (halfTick) flags_next.halfSec = 1'b1;
    if (qtrTick) flags_next.quarterSec = 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      flags_reg     <= '0;
      armed_reg     <= '0;
      matchPrev_reg <= 1'b1; // Time and alarm both reset to 00:00, so no false edge follows reset.
    end
    else
    begin
      flags_reg     <= flags_next;
      matchPrev_reg <= match;
      if (rd && (busIdx_reg == `RTC_IDX_FLAGS))
      begin
        armed_reg <= flags_reg;
      end
      else
      begin
        armed_reg <= armed_reg & ~clrSel;
      end
    end
  end

  // Enables as they stand after this edge, so the request follows an enable write at once.
  assign enablesNext = (wr && (busIdx_reg == `RTC_IDX_IRQ_EN)) ? rtc_flags_t'(wd) : irqEnables_reg;

  // Request output, also the wake source in wait and stop.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(flags_next & enablesNext);
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_sec_wrap: assert property (secTick && sec_reg == `RTC_SEC_MAX && !wr |=> sec_reg == 6'h00)
    else $error("second counter did not wrap to zero");
  a_alarm_set: assert property (match && !matchPrev_reg |=> flags_reg.alarm)
    else $error("alarm flag not set on match");
  a_second_flag: assert property (secTick |=> flags_reg.second && ($changed(sec_reg) || $past(wr)))
    else $error("second flag not set on increment");
  a_date_flag: assert property (dayTick |=> flags_reg.date)
    else $error("day flag not set on day increment");
  a_feb_wrap: assert property (dayTick && !wr && month_reg == `RTC_FEB && day_reg == 5'h1C && year_reg[1:0] != 2'h0
    |=> day_reg == `RTC_DAY_FIRST && month_reg == 4'h3)
    else $error("february did not roll over in a common year");
  a_chrono_hold: assert property (!chronoEnable_reg && !chronoClr |=> $stable(chrono_reg))
    else $error("chronograph moved while disabled");
  a_module_hold: assert property (!run && !wr |=> $stable(sec_reg) && $stable(chrono_reg) && $stable(day_reg))
    else $error("counter moved while module stopped");
  a_freq_lock: assert property (freqLocked_reg |=> $stable(freqSel_reg))
    else $error("frequency select changed after first write");
  a_irq_drop: assert property ((flags_reg & irqEnables_reg) == 8'h00 ##1 (flags_reg & irqEnables_reg) == 8'h00 |-> !irq)
    else $error("request stands with no enabled flag");
  a_chrono_range: assert property (chrono_reg <= 7'h63)
    else $error("chronograph beyond 99");

endmodule

// *** verif/tb_top.sv ***
/*
  Self-checking testbench for the real time clock: register table, alarm, flag clearing,
  chronograph, timebase ticks, enable gating, frequency select lock and stop mode.
  Assumes the design answers as a single AHB-Lite slave whose hreadyout is fed back as hready.
*/
`timescale 1ns/1ns
`include "rtc_consts.svh"

module tb_top;
  import rtc_pkg::*;

  typedef struct {logic [7:0] idx; bit wr; logic [7:0] data; logic [7:0] exp;} reg_row_t;

  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        oscRefClock = 1'b0;
  logic        stopMode = 1'b0;
  logic        oscRunInStop = 1'b0;
  logic        irq;
  logic [31:0] rdata;
  int          mismatches = 0;
  int          comparisons = 0;

  // Reset values first, then writes with in-range and out-of-range data; module stays disabled.
  reg_row_t rows[34] = '{
    '{`RTC_IDX_FLAGS, 0, 8'h00, 8'h00}, '{`RTC_IDX_IRQ_EN, 0, 8'h00, 8'h00}, '{`RTC_IDX_CTRL, 0, 8'h00, 8'h00},
    '{`RTC_IDX_ALM_MIN, 0, 8'h00, 8'h00}, '{`RTC_IDX_ALM_HOUR, 0, 8'h00, 8'h00}, '{`RTC_IDX_SEC, 0, 8'h00, 8'h00},
    '{`RTC_IDX_MIN, 0, 8'h00, 8'h00}, '{`RTC_IDX_HOUR, 0, 8'h00, 8'h00}, '{`RTC_IDX_DAY, 0, 8'h00, 8'h01},
    '{`RTC_IDX_MONTH, 0, 8'h00, 8'h01}, '{`RTC_IDX_YEAR, 0, 8'h00, 8'h00}, '{`RTC_IDX_DOW, 0, 8'h00, 8'h00},
    '{`RTC_IDX_CHRONO, 0, 8'h00, 8'h00}, '{`RTC_IDX_IRQ_EN, 1, 8'hA5, 8'hA5}, '{`RTC_IDX_SEC, 1, 8'h3B, 8'h3B},
    '{`RTC_IDX_SEC, 1, 8'h3C, 8'h3B}, '{`RTC_IDX_MIN, 1, 8'h3C, 8'h00}, '{`RTC_IDX_HOUR, 1, 8'h18, 8'h00},
    '{`RTC_IDX_HOUR, 1, 8'h17, 8'h17}, '{`RTC_IDX_MIN, 1, 8'h3B, 8'h3B}, '{`RTC_IDX_MONTH, 1, 8'h0D, 8'h01},
    '{`RTC_IDX_MONTH, 1, 8'h0C, 8'h0C}, '{`RTC_IDX_MONTH, 1, 8'h00, 8'h0C}, '{`RTC_IDX_DAY, 1, 8'h1F, 8'h1F},
    '{`RTC_IDX_DAY, 1, 8'h20, 8'h1F}, '{`RTC_IDX_DOW, 1, 8'h07, 8'h00}, '{`RTC_IDX_DOW, 1, 8'h06, 8'h06},
    '{`RTC_IDX_YEAR, 1, 8'h9C, 8'h00}, '{`RTC_IDX_YEAR, 1, 8'h9D, 8'h9D}, '{`RTC_IDX_YEAR, 1, 8'h64, 8'h9D},
    '{`RTC_IDX_FLAGS, 1, 8'hFF, 8'h00}, '{`RTC_IDX_CHRONO, 1, 8'h05, 8'h00}, '{8'h50, 1, 8'h5A, 8'h00},
    '{`RTC_IDX_ALM_MIN, 1, 8'h3F, 8'h3F}};

  rtc_calendar_alarm_chrono rtc_calendar_alarm_chrono_i (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .hsel         (hsel),
    .haddr        (haddr),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hsize        (hsize),
    .hwdata       (hwdata),
    .hready       (hreadyout),
    .hreadyout    (hreadyout),
    .hrdata       (hrdata),
    .hresp        (hresp),
    .oscRefClock  (oscRefClock),
    .stopMode     (stopMode),
    .oscRunInStop (oscRunInStop),
    .irq          (irq)
  );

  // Clock of 100 ns period.
  always #50 sys_clk = ~sys_clk;

  // Prints the counts and the verdict, then ends the run.
  task final_report;
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Compares a seen value with the expected one and counts both outcomes.
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Waits for hready sampled high at a rising edge, with a bounded count.
  task waitReady;
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1)
    begin
      n = n + 1;
      if (n > 20)
      begin
        mismatches++;
        $display("[FAIL] bus wait expected ready seen timeout");
        final_report;
      end
      @(posedge sys_clk);
    end
  endtask

  // One single-word transfer; read data is taken at the edge that ends the data phase.
  task busXfer(input bit wr, input logic [7:0] idx, input logic [7:0] data);
    hsel <= 1'b1;
    htrans <= `RTC_HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    waitReady;
    htrans <= 2'h0;
    hwdata <= {24'h0, data};
    waitReady;
    rdata = hrdata;
  endtask

  // Reads a register and compares it with the expected byte.
  task rd(input logic [7:0] idx, input logic [7:0] exp);
    busXfer(1'b0, idx, 8'h00);
    check($sformatf("register %h", idx), rdata, {24'h0, exp});
  endtask

  // Gives a counted number of reference rising edges, one every three system clocks.
  task refEdges(input int n);
    repeat (n)
    begin
      oscRefClock <= 1'b1;
      @(posedge sys_clk);
      oscRefClock <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
  endtask

  // Main sequence: reset, table loop, then the hand-written cases.
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    check("hresp", {31'h0, hresp}, 32'h0);
    foreach (rows[i])
    begin
      if (rows[i].wr)
        busXfer(1'b1, rows[i].idx, rows[i].data);
      rd(rows[i].idx, rows[i].exp);
    end
    // Alarm match made by writes, then the two-step flag clear.
    busXfer(1'b1, `RTC_IDX_ALM_MIN, 8'h05);
    busXfer(1'b1, `RTC_IDX_ALM_HOUR, 8'h03);
    busXfer(1'b1, `RTC_IDX_MIN, 8'h05);
    rd(`RTC_IDX_FLAGS, 8'h00);
    busXfer(1'b1, `RTC_IDX_HOUR, 8'h03);
    rd(`RTC_IDX_ALM_HOUR, 8'h03);
    rd(`RTC_IDX_FLAGS, 8'h80);
    check("irq", {31'h0, irq}, 32'h1);
    rd(`RTC_IDX_ALM_HOUR, 8'h03);
    rd(`RTC_IDX_FLAGS, 8'h00);
    check("irq", {31'h0, irq}, 32'h0);
    // Start with select 000; a second select write must not stick.
    busXfer(1'b1, `RTC_IDX_CTRL, 8'h60);
    busXfer(1'b1, `RTC_IDX_CTRL, 8'h64);
    rd(`RTC_IDX_CTRL, 8'h60);
    // Five 128 Hz ticks store three hundredths; the chrono flag is not enabled.
    refEdges(1280);
    rd(`RTC_IDX_CHRONO, 8'h03);
    rd(`RTC_IDX_FLAGS, 8'h40);
    check("irq", {31'h0, irq}, 32'h0);
    // Chronograph disabled for one tick keeps its value.
    busXfer(1'b1, `RTC_IDX_CTRL, 8'h20);
    refEdges(256);
    rd(`RTC_IDX_CHRONO, 8'h03);
    // Quarter second after 32 divider ticks, chronograph at 31 ticks.
    busXfer(1'b1, `RTC_IDX_CTRL, 8'h60);
    refEdges(6656);
    rd(`RTC_IDX_FLAGS, 8'h41);
    check("irq", {31'h0, irq}, 32'h1);
    rd(`RTC_IDX_CHRONO, 8'h18);
    check("irq", {31'h0, irq}, 32'h0);
    // Half second after 64 divider ticks, chronograph at 63 ticks.
    refEdges(8192);
    rd(`RTC_IDX_FLAGS, 8'h43);
    rd(`RTC_IDX_CHRONO, 8'h31);
    // Chronograph clear zeroes the count and reads back as 0.
    busXfer(1'b1, `RTC_IDX_CTRL, 8'hE0);
    rd(`RTC_IDX_CTRL, 8'h60);
    rd(`RTC_IDX_CHRONO, 8'h00);
    rd(`RTC_IDX_DOW, 8'h06);
    // Module disabled: nothing counts and the values stay.
    busXfer(1'b1, `RTC_IDX_CTRL, 8'h40);
    refEdges(512);
    rd(`RTC_IDX_CHRONO, 8'h00);
    rd(`RTC_IDX_CTRL, 8'h40);
    // Stop mode halts counting unless the oscillator runs in stop.
    busXfer(1'b1, `RTC_IDX_CTRL, 8'h60);
    stopMode <= 1'b1;
    refEdges(512);
    rd(`RTC_IDX_CHRONO, 8'h00);
    oscRunInStop <= 1'b1;
    refEdges(512);
    rd(`RTC_IDX_CHRONO, 8'h01);
    // Reset in mid-run: registers clear, no false alarm at 00:00, and the select field unlocks.
    stopMode <= 1'b0;
    oscRunInStop <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check("hreadyout", {31'h0, hreadyout}, 32'h1);
    check("irq", {31'h0, irq}, 32'h0);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(`RTC_IDX_FLAGS, 8'h00);
    rd(`RTC_IDX_IRQ_EN, 8'h00);
    rd(`RTC_IDX_CTRL, 8'h00);
    busXfer(1'b1, `RTC_IDX_CTRL, 8'h62);
    rd(`RTC_IDX_CTRL, 8'h62);
    // One 100 Hz tick from the 32 kHz divider stores one hundredth directly.
    refEdges(320);
    rd(`RTC_IDX_CHRONO, 8'h01);
    final_report;
  end

endmodule
